//--- ctsp_host_model.sv
// host side model issuing system output mode writes
`timescale 1ns/1ps
module ctsp_host_model
(
    input  logic       core_clk,
    output logic [1:0] modeWriteData,
    output logic       modeWriteStrobe
);
    initial
    begin
        modeWriteData   = 2'h0;
        modeWriteStrobe = 1'h0;
    end
    // one-cycle strobe; data inverted afterwards so nothing stale looks valid
    task automatic write_mode(input logic [1:0] value);
        @(negedge core_clk);
        modeWriteData   <= value;
        modeWriteStrobe <= 1'h1;
        @(negedge core_clk);
        modeWriteStrobe <= 1'h0;
        modeWriteData   <= ~value;
    endtask : write_mode
endmodule : ctsp_host_model

//--- ctsp_path_chk.sv
// assertion checker for the path control block
`timescale 1ns/1ps
module ctsp_path_chk
    import ctsp_pkg::*;
(
    input logic                core_clk,
    input logic                rst_b,
    input logic                inputValidRaw,
    input logic                batAboveLockoutRaw,
    input logic                timer_double_enable,
    input logic                modeWriteStrobe,
    input logic [1:0]          modeWriteData,
    input logic [1:0]          sys_source_select,
    input logic                inputSwitchOn,
    input logic                battery_switch,
    input logic                sysPulldownOn,
    input logic                chargeActive,
    input logic                supplementActive,
    input logic                safetyTimerReset,
    input logic                safetyTimerHalfRate,
    input logic [ctsp_pkg::TARGET_W-1:0] effectiveTarget
);
    // ------------------------------------------------------------
    // path and charge properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    AST_CLAMP: assert property (effectiveTarget <= TARGET_MAX)
        else $error("target above ceiling");
    AST_PULLDN: assert property (sys_source_select == MODE_PULLDN
        |-> sysPulldownOn && !inputSwitchOn && !battery_switch)
        else $error("pulled down mode wrong");
    AST_FLOAT: assert property (sys_source_select == MODE_FLOAT
        |-> !sysPulldownOn && !inputSwitchOn && !battery_switch)
        else $error("floating mode wrong");
    // one cycle of slack: charge state may trail the mode field
    AST_FORCE: assert property ((sys_source_select == MODE_FORCE) [*2]
        |-> !inputSwitchOn && !chargeActive)
        else $error("forced battery still charging");
    AST_SUPLOCK: assert property (!batAboveLockoutRaw [*5] |-> !supplementActive)
        else $error("supplement below lockout");
    AST_TMRPULSE: assert property (safetyTimerReset |=> !safetyTimerReset)
        else $error("timer reset not a pulse");
    AST_HALF: assert property (!timer_double_enable [*3] |-> !safetyTimerHalfRate)
        else $error("half rate without enable");
    AST_MODEWR: assert property (inputValidRaw [*6] ##0
        (modeWriteStrobe && modeWriteData != MODE_FORCE)
        |-> ##2 sys_source_select == $past(modeWriteData, 2))
        else $error("mode write lost");
    AST_INDROP: assert property ($fell(inputValidRaw)
        ##1 (!inputValidRaw && !modeWriteStrobe) [*6] |-> sys_source_select == MODE_NORMAL)
        else $error("input drop kept mode");
endmodule : ctsp_path_chk

//--- ctsp_path_ctrl.sv
// charge termination and system output path control
`timescale 1ns/1ps
module ctsp_path_ctrl
    import ctsp_pkg::*;
(
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    input  wire logic                          inputValidRaw,
    input  wire logic                          batAboveLockoutRaw,
    input  wire logic                          rechargeReachedRaw,
    input  wire logic                          cvLoopActiveRaw,
    input  wire logic                          atTerminationRaw,
    input  wire logic                          inputVoltageLoopRaw,
    input  wire logic                          inputCurrentLoopRaw,
    input  wire logic                          thermalRegRaw,
    input  wire logic                          headroomLowRaw,
    input  wire logic                          supplementEnterRaw,
    input  wire logic                          supplementExitRaw,
    input  wire logic                          fastChargeRaw,
    input  wire logic                          thermistorFaultRaw,
    input  wire logic                          shipModeRaw,
    input  wire logic                          hardResetRaw,
    input  wire logic                          wakeTimerDone,
    input  wire logic                          chargeEnable,
    input  wire logic [1:0]                    modeWriteData,
    input  wire logic                          modeWriteStrobe,
    input  wire logic                          input_voltage_threshold_sel_lo,
    input  wire logic                          input_voltage_threshold_sel_hi,
    input  wire logic                          sys_headroom_loop_off,
    input  wire logic                          batteryTrackingMode,
    input  wire logic                          timer_double_enable,
    input  wire logic [ctsp_pkg::TARGET_W-1:0] battery_target_voltage,
    output logic [1:0]                         sys_source_select,
    output logic                               inputSwitchOn,
    output logic                               battery_switch,
    output logic                               sysPulldownOn,
    output logic                               chargeActive,
    output logic                               fastChargeCurrentOn,
    output logic                               chargeDone,
    output logic                               input_voltage_loop_flag,
    output logic                               inputVoltageLoopEnable,
    output logic                               inputCurrentLoopEnable,
    output logic                               headroomLoopEnable,
    output logic                               supplementActive,
    output logic                               safetyTimerReset,
    output logic                               safetyTimerHalfRate,
    output logic [ctsp_pkg::TARGET_W-1:0]      effectiveTarget
);
    import ctsp_pkg::*;

    // ------------------------------------------------------------------
    // flag synchronizers
    // ------------------------------------------------------------------
    logic [SYNC_FLAGS-1:0] rawFlags;
    logic [SYNC_FLAGS-1:0] syncA_reg;
    logic [SYNC_FLAGS-1:0] syncB_reg;
    logic [SYNC_FLAGS-1:0] syncA_next;
    logic [SYNC_FLAGS-1:0] syncB_next;

    assign rawFlags = {hardResetRaw, shipModeRaw, thermistorFaultRaw, fastChargeRaw,
                       supplementExitRaw, supplementEnterRaw, headroomLowRaw, thermalRegRaw,
                       inputCurrentLoopRaw, inputVoltageLoopRaw, atTerminationRaw,
                       cvLoopActiveRaw, rechargeReachedRaw, batAboveLockoutRaw,
                       inputValidRaw};

    always_comb
    begin
        syncA_next = rawFlags; // (R23)
        syncB_next = syncA_reg;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end
        else
        begin
            syncA_reg <= syncA_next;
            syncB_reg <= syncB_next;
        end
    end

    // ------------------------------------------------------------------
    // mode field and pulldown hold
    // ------------------------------------------------------------------
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic       inPrev_reg;
    logic       inPrev_next;
    logic       hrHold_reg;
    logic       hrHold_next;
    logic       inDrop;
    logic       inOk;
    logic       batOk;

    assign inOk   = syncB_reg[FL_INOK];
    assign batOk  = syncB_reg[FL_BATOK];
    // input removal seen as the valid flag falling
    assign inDrop = inPrev_reg && !inOk;

    always_comb
    begin
        mode_next   = mode_reg;
        inPrev_next = inOk;
        hrHold_next = hrHold_reg;
        if (modeWriteStrobe)
        begin
            if (modeWriteData == MODE_FORCE && !batOk)
                mode_next = MODE_NORMAL; // (R17)
            else
                mode_next = modeWriteData; // (R15)
        end
        else if (mode_reg == MODE_FORCE && !batOk)
            mode_next = MODE_NORMAL; // (R17)
        if (inDrop)
            mode_next = MODE_NORMAL; // (R18)
        // hard reset pulldown survives until the wake timer fires
        if (syncB_reg[FL_HWRST])
            hrHold_next = 1'b1; // (R21)
        else if (wakeTimerDone)
            hrHold_next = 1'b0; // (R21)
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_reg   <= MODE_NORMAL;
            inPrev_reg <= 1'b0;
            hrHold_reg <= 1'b0;
        end
        else
        begin
            mode_reg   <= mode_next;
            inPrev_reg <= inPrev_next;
            hrHold_reg <= hrHold_next;
        end
    end

    // ------------------------------------------------------------------
    // charge state and supplement
    // ------------------------------------------------------------------
    ctsp_chg_e chg_reg;
    ctsp_chg_e chg_next;
    logic      sup_reg;
    logic      sup_next;
    logic      headLoop;
    logic      termBlock;
    logic      chargeAllowed;
    logic      timerRst;

    // tracking mode keeps the headroom loop in force regardless of the off bit
    assign headLoop      = syncB_reg[FL_HEAD]
                           && (!sys_headroom_loop_off || batteryTrackingMode); // (R11) (R12)
    assign termBlock     = syncB_reg[FL_VLOOP] || syncB_reg[FL_THERM] || headLoop
                           || sup_reg; // (R05) (R14)
    assign chargeAllowed = chargeEnable && inOk && mode_reg == MODE_NORMAL; // (R19) (R20)

    always_comb
    begin
        chg_next = chg_reg;
        sup_next = sup_reg;
        timerRst = 1'b0;
        // charge current is gone when not in CHG_RUN (idle or done) or throttled to zero by the headroom loop
        if (!sup_reg && syncB_reg[FL_SUPIN] && (chg_reg != CHG_RUN || headLoop) && batOk)
            sup_next = 1'b1; // (R13) (R14)
        else if (sup_reg && (syncB_reg[FL_SUPOUT] || !batOk))
            sup_next = 1'b0; // (R13) (R14)
        unique case (chg_reg)
            CHG_IDLE:
            begin
                if (chargeAllowed)
                begin
                    chg_next = CHG_RUN;
                    timerRst = 1'b1;
                end
            end
            CHG_RUN:
            begin
                if (!chargeAllowed)
                    chg_next = CHG_IDLE; // (R19)
                else if (syncB_reg[FL_FAST] && syncB_reg[FL_CV]
                         && syncB_reg[FL_ATTERM] && !termBlock)
                    chg_next = CHG_DONE; // (R02) (R05)
            end
            CHG_DONE:
            begin
                if (!chargeAllowed)
                    chg_next = CHG_IDLE;
                else if (syncB_reg[FL_RECH])
                begin
                    chg_next = CHG_RUN; // (R06)
                    timerRst = 1'b1; // (R06)
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chg_reg <= CHG_IDLE;
            sup_reg <= 1'b0;
        end
        else
        begin
            chg_reg <= chg_next;
            sup_reg <= sup_next;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    logic                srcIn;
    logic                srcBat;
    logic                pullDn;
    logic                ivlEn;
    logic [TARGET_W-1:0] tgt;

    always_comb
    begin
        srcIn  = 1'b0;
        srcBat = 1'b0;
        pullDn = 1'b0;
        unique case (mode_reg)
            MODE_NORMAL:
            begin
                srcIn  = inOk; // (R16) (R04)
                srcBat = !inOk && batOk; // (R16)
            end
            MODE_FORCE:
                srcBat = batOk;
            MODE_FLOAT:
                pullDn = 1'b0; // (R20)
            MODE_PULLDN:
                pullDn = 1'b1; // (R22)
        endcase
        // ship and hard reset open every switch and engage the pulldown; hard reset acts a cycle after ship, through the hold register
        if (syncB_reg[FL_SHIP] || hrHold_reg)
        begin
            srcIn  = 1'b0;
            srcBat = 1'b0;
            pullDn = 1'b1; // (R21)
        end
        // only normal mode may reopen the battery path; off modes keep it open
        if ((chg_reg == CHG_RUN || sup_reg) && mode_reg == MODE_NORMAL)
            srcBat = srcBat || (batOk && !syncB_reg[FL_SHIP] && !hrHold_reg); // (R13)
        if (chg_reg == CHG_DONE && !sup_reg && srcIn)
            srcBat = 1'b0; // (R04)
        // both selects low means the loop is disabled
        ivlEn = input_voltage_threshold_sel_lo || input_voltage_threshold_sel_hi; // (R07)
        tgt   = (battery_target_voltage > TARGET_MAX) ? TARGET_MAX
                                                       : battery_target_voltage; // (R03)
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sys_source_select       <= MODE_NORMAL;
            inputSwitchOn           <= 1'b0;
            battery_switch          <= 1'b0;
            sysPulldownOn           <= 1'b0;
            chargeActive            <= 1'b0;
            fastChargeCurrentOn     <= 1'b0;
            chargeDone              <= 1'b0;
            input_voltage_loop_flag <= 1'b0;
            inputVoltageLoopEnable  <= 1'b0;
            inputCurrentLoopEnable  <= 1'b0;
            headroomLoopEnable      <= 1'b0;
            supplementActive        <= 1'b0;
            safetyTimerReset        <= 1'b0;
            safetyTimerHalfRate     <= 1'b0;
            effectiveTarget         <= '0;
        end
        else
        begin
            sys_source_select       <= mode_reg;
            inputSwitchOn           <= srcIn;
            battery_switch          <= srcBat;
            sysPulldownOn           <= pullDn;
            chargeActive            <= chg_reg == CHG_RUN && !sup_reg;
            fastChargeCurrentOn     <= chg_reg == CHG_RUN && syncB_reg[FL_FAST]
                                       && !syncB_reg[FL_CV] && !syncB_reg[FL_THFAULT]
                                       && !syncB_reg[FL_VLOOP] && !syncB_reg[FL_THERM]
                                       && !headLoop; // (R01)
            chargeDone              <= chg_reg == CHG_DONE; // (R02)
            input_voltage_loop_flag <= ivlEn && syncB_reg[FL_VLOOP]; // (R08)
            inputVoltageLoopEnable  <= ivlEn; // (R07)
            inputCurrentLoopEnable  <= srcIn; // (R10)
            headroomLoopEnable      <= !sys_headroom_loop_off || batteryTrackingMode; // (R12)
            supplementActive        <= sup_reg; // (R13)
            safetyTimerReset        <= timerRst; // (R06)
            safetyTimerHalfRate     <= timer_double_enable && ivlEn
                                       && syncB_reg[FL_VLOOP]; // (R09)
            effectiveTarget         <= tgt; // (R03)
        end
    end
endmodule : ctsp_path_ctrl

//--- ctsp_pkg.sv
// constants for the charge termination and system path control block
// ----------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------
// Operation
// (R01) cc loop charges at programmed fast current
// (R02) charge done when current tapers to termination
// (R03) clamp battery target to ceiling code
// (R04) after termination battery switch off, input feeds
// (R05) terminate only in cv, not when limited; the input current loop flag is not checked
// (R06) recharge threshold restarts cycle, resets timers
// (R07) input voltage loop, two select bits, disableable
// (R08) input voltage loop flag while loop active
// (R09) timer doubling slows timer under input loop
// (R10) input current limit loop reduces input current
// (R11) headroom loop reduces charge, inhibits termination
// (R12) headroom off bit ignored in tracking mode
// (R13) supplement enters and exits on margins
// (R14) supplement inhibits termination, needs battery above lockout
// (R15) two bit system output mode field
// (R16) default mode: input if valid, else battery
// (R17) forced battery refused below lockout, back to 00
// (R18) input drop resets mode field to 00
// (R19) forced battery mode stops charging
// (R20) floating off: disconnect, pulldown off
// (R21) pulldown on ship and hard reset until wake
// (R22) pulled down mode holds until write or input toggle
// (R23) analog flags synchronized to clock
package ctsp_pkg;
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_FORCE   = 2'h1;
    localparam logic [1:0] MODE_FLOAT   = 2'h2;
    localparam logic [1:0] MODE_PULLDN  = 2'h3;
    localparam int         TARGET_W     = 7;
    // target code of the 4.65 V ceiling at 10 mV steps from 3.6 V
    localparam logic [6:0] TARGET_MAX   = 7'h69;
    localparam int         SYNC_FLAGS   = 15;
    localparam int         FL_INOK      = 0;
    localparam int         FL_BATOK     = 1;
    localparam int         FL_RECH      = 2;
    localparam int         FL_CV        = 3;
    localparam int         FL_ATTERM    = 4;
    localparam int         FL_VLOOP     = 5;
    localparam int         FL_ILOOP     = 6;
    localparam int         FL_THERM     = 7;
    localparam int         FL_HEAD      = 8;
    localparam int         FL_SUPIN     = 9;
    localparam int         FL_SUPOUT    = 10;
    localparam int         FL_FAST      = 11;
    localparam int         FL_THFAULT   = 12;
    localparam int         FL_SHIP      = 13;
    localparam int         FL_HWRST     = 14;
    typedef enum logic [2:0]
    {
        CHG_IDLE = 3'b001,
        CHG_RUN  = 3'b010,
        CHG_DONE = 3'b100
    } ctsp_chg_e;
endpackage : ctsp_pkg

//--- testbench.sv
// self-checking bench for the path control block
`timescale 1ns/1ps
module testbench;
    import ctsp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                  core_clk, rst_b, seen, wakeTimerDone, chargeEnable;
    logic [SYNC_FLAGS-1:0] rawFlags;
    logic                  batteryTrackingMode, sys_headroom_loop_off, timer_double_enable;
    logic                  input_voltage_threshold_sel_lo, input_voltage_threshold_sel_hi;
    logic [1:0]            sys_source_select, modeWriteData;
    logic [TARGET_W-1:0]   battery_target_voltage, effectiveTarget;
    logic                  modeWriteStrobe, inputSwitchOn, battery_switch, sysPulldownOn;
    logic                  chargeActive, fastChargeCurrentOn, chargeDone, supplementActive;
    logic                  input_voltage_loop_flag, inputVoltageLoopEnable, headroomLoopEnable;
    logic                  inputCurrentLoopEnable, safetyTimerReset, safetyTimerHalfRate;
    logic [6:0]            codes [5] = '{7'h00, 7'h68, 7'h69, 7'h6A, 7'h7F};
    logic [6:0]            clamped [5] = '{7'h00, 7'h68, 7'h69, 7'h69, 7'h69};
    int                    num_errors, n_tests, cycleCount;

    ctsp_path_ctrl dut
    (
        .core_clk, .rst_b, .wakeTimerDone, .chargeEnable, .modeWriteData, .modeWriteStrobe,
        .input_voltage_threshold_sel_lo, .input_voltage_threshold_sel_hi,
        .sys_headroom_loop_off, .batteryTrackingMode, .timer_double_enable,
        .battery_target_voltage, .sys_source_select, .inputSwitchOn, .battery_switch,
        .sysPulldownOn, .chargeActive, .fastChargeCurrentOn, .chargeDone,
        .input_voltage_loop_flag, .inputVoltageLoopEnable, .inputCurrentLoopEnable,
        .headroomLoopEnable, .supplementActive, .safetyTimerReset, .safetyTimerHalfRate,
        .effectiveTarget,
        .inputValidRaw(rawFlags[FL_INOK]), .batAboveLockoutRaw(rawFlags[FL_BATOK]),
        .rechargeReachedRaw(rawFlags[FL_RECH]), .cvLoopActiveRaw(rawFlags[FL_CV]),
        .atTerminationRaw(rawFlags[FL_ATTERM]), .inputVoltageLoopRaw(rawFlags[FL_VLOOP]),
        .inputCurrentLoopRaw(rawFlags[FL_ILOOP]), .thermalRegRaw(rawFlags[FL_THERM]),
        .headroomLowRaw(rawFlags[FL_HEAD]), .supplementEnterRaw(rawFlags[FL_SUPIN]),
        .supplementExitRaw(rawFlags[FL_SUPOUT]), .fastChargeRaw(rawFlags[FL_FAST]),
        .thermistorFaultRaw(rawFlags[FL_THFAULT]), .shipModeRaw(rawFlags[FL_SHIP]),
        .hardResetRaw(rawFlags[FL_HWRST])
    );
    ctsp_host_model host
    (
        .core_clk, .modeWriteData, .modeWriteStrobe
    );

    always #20 core_clk = ~core_clk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    // raw flags pass a synchroniser, so allow generous settling
    task automatic fl(input int i, input logic v);
        rawFlags[i] = v;
        cyc(7);
    endtask : fl
    task automatic mode(input logic [1:0] v);
        host.write_mode(v);
        cyc(4);
    endtask : mode
    task automatic chk_vec(input string what, input logic [6:0] exp, input logic [6:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_vec(what, {6'h00, exp}, {6'h00, got});
    endtask : chk_bit
    task automatic chk_path(input logic [1:0] m, input logic i, input logic b, input logic p);
        chk_vec("mode", {5'h00, m}, {5'h00, sys_source_select});
        chk_bit("in switch", i, inputSwitchOn);
        chk_bit("bat switch", b, battery_switch);
        chk_bit("pulldown", p, sysPulldownOn);
    endtask : chk_path
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    always @(posedge core_clk)
    begin
        cycleCount++;
        if (cycleCount == 2000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        {core_clk, rst_b, seen, wakeTimerDone, chargeEnable, batteryTrackingMode} = 6'h00;
        {sys_headroom_loop_off, timer_double_enable} = 2'h0;
        {input_voltage_threshold_sel_lo, input_voltage_threshold_sel_hi} = 2'h0;
        rawFlags = '0;
        battery_target_voltage = 7'h00;
        cyc(20);
        rst_b = 1'h1;
        chk_path(MODE_NORMAL, 1'h0, 1'h0, 1'h0);
        chk_bit("vin loop en", 1'h0, inputVoltageLoopEnable);
        foreach (codes[k])
        begin
            battery_target_voltage = codes[k];
            cyc(3);
            chk_vec("target", clamped[k], effectiveTarget);
        end
        $display("test clamp done");
        rawFlags[FL_BATOK] = 1'h1;
        fl(FL_INOK, 1'h1);
        chk_path(MODE_NORMAL, 1'h1, 1'h0, 1'h0);
        chk_bit("ilim en", 1'h1, inputCurrentLoopEnable);
        mode(MODE_PULLDN);
        chk_path(MODE_PULLDN, 1'h0, 1'h0, 1'h1);
        chk_bit("ilim en", 1'h0, inputCurrentLoopEnable);
        mode(MODE_FLOAT);
        chk_path(MODE_FLOAT, 1'h0, 1'h0, 1'h0);
        mode(MODE_FORCE);
        chk_path(MODE_FORCE, 1'h0, 1'h1, 1'h0);
        fl(FL_BATOK, 1'h0);
        chk_path(MODE_NORMAL, 1'h1, 1'h0, 1'h0);
        mode(MODE_FORCE);
        chk_path(MODE_NORMAL, 1'h1, 1'h0, 1'h0);
        fl(FL_BATOK, 1'h1);
        mode(MODE_PULLDN);
        fl(FL_INOK, 1'h0);
        chk_path(MODE_NORMAL, 1'h0, 1'h1, 1'h0);
        fl(FL_INOK, 1'h1);
        $display("test modes done");
        input_voltage_threshold_sel_lo = 1'h1;
        chargeEnable = 1'h1;
        fl(FL_FAST, 1'h1);
        chk_bit("active", 1'h1, chargeActive);
        chk_bit("fast", 1'h1, fastChargeCurrentOn);
        chk_bit("vin loop en", 1'h1, inputVoltageLoopEnable);
        fl(FL_THERM, 1'h1);
        chk_bit("fast", 1'h0, fastChargeCurrentOn);
        fl(FL_THERM, 1'h0);
        timer_double_enable = 1'h1;
        fl(FL_VLOOP, 1'h1);
        fl(FL_CV, 1'h1);
        fl(FL_ATTERM, 1'h1);
        chk_bit("done", 1'h0, chargeDone);
        chk_bit("vloop", 1'h1, input_voltage_loop_flag);
        chk_bit("half", 1'h1, safetyTimerHalfRate);
        fl(FL_VLOOP, 1'h0);
        chk_bit("done", 1'h1, chargeDone);
        chk_path(MODE_NORMAL, 1'h1, 1'h0, 1'h0);
        fl(FL_ATTERM, 1'h0);
        fl(FL_CV, 1'h0);
        rawFlags[FL_RECH] = 1'h1;
        repeat (10)
        begin
            cyc(1);
            seen = seen | safetyTimerReset;
        end
        chk_bit("timer reset", 1'h1, seen);
        chk_bit("done", 1'h0, chargeDone);
        fl(FL_RECH, 1'h0);
        $display("test charge done");
        sys_headroom_loop_off = 1'h1;
        cyc(4);
        chk_bit("headroom", 1'h0, headroomLoopEnable);
        batteryTrackingMode = 1'h1;
        cyc(4);
        chk_bit("headroom", 1'h1, headroomLoopEnable);
        sys_headroom_loop_off = 1'h0;
        fl(FL_HEAD, 1'h1);
        fl(FL_CV, 1'h1);
        fl(FL_ATTERM, 1'h1);
        chk_bit("done", 1'h0, chargeDone);
        fl(FL_SUPIN, 1'h1);
        chk_bit("supplement", 1'h1, supplementActive);
        fl(FL_HEAD, 1'h0);
        chk_bit("done", 1'h0, chargeDone);
        fl(FL_SUPIN, 1'h0);
        fl(FL_SUPOUT, 1'h1);
        chk_bit("supplement", 1'h0, supplementActive);
        rawFlags[FL_ATTERM] = 1'h0;
        fl(FL_SUPOUT, 1'h0);
        $display("test headroom done");
        fl(FL_HWRST, 1'h1);
        chk_bit("pulldown", 1'h1, sysPulldownOn);
        fl(FL_HWRST, 1'h0);
        chk_bit("pulldown", 1'h1, sysPulldownOn);
        wakeTimerDone = 1'h1;
        cyc(1);
        wakeTimerDone = 1'h0;
        cyc(4);
        chk_bit("pulldown", 1'h0, sysPulldownOn);
        fl(FL_SHIP, 1'h1);
        chk_bit("pulldown", 1'h1, sysPulldownOn);
        $display("test pulldown done");
        give_verdict();
    end
endmodule : testbench

bind ctsp_path_ctrl ctsp_path_chk chk
(
    .core_clk, .rst_b, .inputValidRaw, .batAboveLockoutRaw, .timer_double_enable,
    .modeWriteStrobe, .modeWriteData, .sys_source_select, .inputSwitchOn, .battery_switch,
    .sysPulldownOn, .chargeActive, .supplementActive, .safetyTimerReset,
    .safetyTimerHalfRate, .effectiveTarget
);
